// [sep_pkg.sv]
// ****************************************************************
// Shared constants of the serial EEPROM slave
// ****************************************************************
package sep_pkg;

  localparam int clk_hz = 10_000_000;
  localparam int prog_time_ms = 5;
  // Longest time, so the cycle count rounds down
  localparam int prog_cycles_dflt = prog_time_ms * (clk_hz / 1000);

  localparam int addr_w = 11;
  localparam int mem_depth = 2048;
  localparam int page_max = 32;
  localparam int page_dflt = 16;
  localparam int off_w = 5;

  localparam logic [7:0] op_read = 8'h03;
  localparam logic [7:0] op_write = 8'h02;
  localparam logic [7:0] op_latch_clear = 8'h04;
  localparam logic [7:0] op_latch_set = 8'h06;
  localparam logic [7:0] op_status_read = 8'h05;

  localparam logic [4:0] cmd_last_bit = 5'h07;
  localparam logic [4:0] addr_last_bit = 5'h0f;
  localparam logic [4:0] byte_last_bit = 5'h07;
  localparam logic [4:0] cnt_zero = 5'h00;
  localparam logic [2:0] out_last_bit = 3'h7;
  localparam logic [2:0] out_zero = 3'h0;

  localparam int st_busy_bit = 0;
  localparam int st_latch_bit = 1;
  localparam int st_bp0_bit = 2;
  localparam int st_bp1_bit = 3;
  localparam int st_protect_pin_enable_bit = 7;

  // Order of the synchronised pin bank
  localparam int pin_cs = 0;
  localparam int pin_sck = 1;
  localparam int pin_si = 2;
  localparam int pin_hold = 3;
  localparam int pin_protect_pin_enable = 4;
  localparam int pin_bp1 = 5;
  localparam int pin_bp0 = 6;
  localparam int pin_count = 7;
  localparam logic [6:0] pin_idle = 7'h09;

endpackage

// [sep_sync.sv]
// ****************************************************************
// Two-stage synchroniser bank for pin inputs
// ****************************************************************
module sep_sync
  import sep_pkg::*;
#(
  parameter int width = 1,
  parameter logic [width-1:0] idle_val = '0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);

  logic [width-1:0] stage1_reg;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_reg <= idle_val;
      sync_out <= idle_val;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule // sep_sync

// [sep_core.sv]
// ****************************************************************
// Serial EEPROM slave: command, read stream, page write, program
// ****************************************************************

// Operation
// - Sample data input on serial clock rise
// - Eight-bit instruction shift register before decode
// - All fields shift most significant bit first
// - First instruction bit after select falls
// - Hold pauses sequence; resume at same point
// - Stream stored byte at address on output
// - Pointer advances after each byte out
// - Pointer rolls from top address to zero
// - Select rise ends read output
// - Latch set only on select rise after opcode
// - Up to one page of bytes per write
// - Write data wraps within the same page
// - Program only when select rises after byte
// - Program cycle starts at select rise, 5 ms
// - Status reads answered during program cycle
// - Array reads refused during program cycle
// - Program completion clears write latch
// - Read opcode 03, write opcode 02
// - Latch set 06, latch clear 04
// - Status bit0 busy, bit1 write latch
// - Output released while select high
module sep_core
  import sep_pkg::*;
#(
  parameter int page_bytes = page_dflt,
  parameter int prog_cycles = prog_cycles_dflt
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic hold_n_pin,
  input wire logic protect_pin_enable,
  input wire logic block_protect_high,
  input wire logic block_protect_low,
  output logic so_out,
  output logic so_oe,
  output logic program_busy_flag,
  output logic write_latch_flag
);

  typedef enum logic [3:0]
    {st_idle, st_cmd, st_addr_rd, st_addr_wr, st_rd_data, st_wr_data, st_stat_out,
     st_set_wait, st_clr_wait, st_ignore} sep_state_type;

  localparam logic [addr_w-1:0] off_mask = addr_w'(page_bytes - 1);
  localparam logic [31:0] prog_last = 32'(prog_cycles - 1);

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  logic [pin_count-1:0] pins_async;
  logic [pin_count-1:0] pins_sync;
  logic cs_prev_reg, sck_prev_reg, cs_s, hold_s, si_s;
  logic cs_fall, cs_rise, sck_rise, sck_fall;

  assign pins_async = {block_protect_low, block_protect_high, protect_pin_enable,
                       hold_n_pin, si_pin, sck_pin, cs_n_pin};

  sep_sync #(.width(pin_count), .idle_val(pin_idle)) u_sync (.clk(sys_clk), .rst(sys_rst),
    .async_in(pins_async), .sync_out(pins_sync));

  assign cs_s = pins_sync[pin_cs];
  assign hold_s = pins_sync[pin_hold];
  assign si_s = pins_sync[pin_si];

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cs_prev_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
    end
    else
    begin
      cs_prev_reg <= cs_s;
      sck_prev_reg <= pins_sync[pin_sck];
    end
  end

  assign cs_fall = cs_prev_reg & ~cs_s;
  assign cs_rise = ~cs_prev_reg & cs_s;
  // Clock edges count only while selected and not held
  assign sck_rise = pins_sync[pin_sck] & ~sck_prev_reg & ~cs_s & hold_s;
  assign sck_fall = ~pins_sync[pin_sck] & sck_prev_reg & ~cs_s & hold_s;

  // ****************************************************************
  // Shared state
  // ****************************************************************
  sep_state_type state_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] in_sh_reg, in_next;
  logic [7:0] mem [mem_depth];
  logic [7:0] page_buf [page_max];
  logic [page_max-1:0] buf_valid_reg;
  logic [addr_w-1:0] ptr_reg, ptr_inc, page_base_reg;
  logic [7:0] out_sh_reg, status_byte;
  logic [2:0] out_cnt_reg;
  logic out_started_reg, busy_reg, wel_reg, prog_done, out_state;
  logic [31:0] prog_cnt_reg;

  // Incoming bit enters at the bottom, so the first bit ends up on top
  assign in_next = {in_sh_reg[14:0], si_s};
  assign ptr_inc = ptr_reg + 11'h001;
  assign out_state = (state_reg == st_rd_data) || (state_reg == st_stat_out);
  assign prog_done = busy_reg && (prog_cnt_reg == prog_last);

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[st_busy_bit] = busy_reg;
    status_byte[st_latch_bit] = wel_reg;
    status_byte[st_bp0_bit] = pins_sync[pin_bp0];
    status_byte[st_bp1_bit] = pins_sync[pin_bp1];
    status_byte[st_protect_pin_enable_bit] = pins_sync[pin_protect_pin_enable];
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= st_idle;
      bit_cnt_reg <= cnt_zero;
      in_sh_reg <= 16'h0000;
    end
    else if (cs_s)
    begin
      // Deselect aborts whatever was in flight
      state_reg <= st_idle;
      bit_cnt_reg <= cnt_zero;
    end
    else if (cs_fall)
    begin
      state_reg <= st_cmd;
      bit_cnt_reg <= cnt_zero;
    end
    else if (sck_rise)
    begin
      in_sh_reg <= in_next;
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      case (state_reg)
        st_cmd:
        begin
          if (bit_cnt_reg == cmd_last_bit)
          begin
            bit_cnt_reg <= cnt_zero;
            case (in_next[7:0])
              op_read: state_reg <= busy_reg ? st_ignore : st_addr_rd;
              op_write: state_reg <= (wel_reg && !busy_reg) ? st_addr_wr : st_ignore;
              op_latch_set: state_reg <= st_set_wait;
              op_latch_clear: state_reg <= st_clr_wait;
              op_status_read: state_reg <= st_stat_out;
              default: state_reg <= st_ignore;
            endcase
          end
        end
        st_addr_rd:
        begin
          if (bit_cnt_reg == addr_last_bit)
          begin
            bit_cnt_reg <= cnt_zero;
            state_reg <= st_rd_data;
          end
        end
        st_addr_wr:
        begin
          if (bit_cnt_reg == addr_last_bit)
          begin
            bit_cnt_reg <= cnt_zero;
            state_reg <= st_wr_data;
          end
        end
        st_wr_data:
        begin
          if (bit_cnt_reg == byte_last_bit)
            bit_cnt_reg <= cnt_zero;
        end
        // Any extra clock after a latch opcode voids it
        st_set_wait: state_reg <= st_ignore;
        st_clr_wait: state_reg <= st_ignore;
        default: bit_cnt_reg <= cnt_zero;
      endcase
    end
  end

  // ****************************************************************
  // Address pointer and output shifter
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ptr_reg <= '0;
      page_base_reg <= '0;
      out_sh_reg <= 8'h00;
      out_cnt_reg <= out_zero;
      so_out <= 1'b0;
    end
    else if (sck_rise)
    begin
      if ((state_reg == st_cmd) && (bit_cnt_reg == cmd_last_bit))
      begin
        out_sh_reg <= status_byte;
        out_cnt_reg <= out_zero;
      end
      else if ((state_reg == st_addr_rd) && (bit_cnt_reg == addr_last_bit))
      begin
        // Upper five address bits are dropped here
        ptr_reg <= in_next[addr_w-1:0];
        out_sh_reg <= mem[in_next[addr_w-1:0]];
        out_cnt_reg <= out_zero;
      end
      else if ((state_reg == st_addr_wr) && (bit_cnt_reg == addr_last_bit))
      begin
        ptr_reg <= in_next[addr_w-1:0];
        page_base_reg <= in_next[addr_w-1:0] & ~off_mask;
      end
      else if ((state_reg == st_wr_data) && (bit_cnt_reg == byte_last_bit))
        ptr_reg <= (ptr_reg & ~off_mask) | (ptr_inc & off_mask);
    end
    else if (sck_fall && out_state)
    begin
      // Each falling edge presents the next bit, top bit first
      so_out <= out_sh_reg[7];
      if (out_cnt_reg == out_last_bit)
      begin
        out_cnt_reg <= out_zero;
        if (state_reg == st_rd_data)
        begin
          ptr_reg <= ptr_inc;
          out_sh_reg <= mem[ptr_inc];
        end
        else
        begin
          // Status is re-sampled for every repeat so busy can be polled
          out_sh_reg <= status_byte;
        end
      end
      else
      begin
        out_cnt_reg <= out_cnt_reg + 3'h1;
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Output enable
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      out_started_reg <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      if (cs_s || !out_state)
        out_started_reg <= 1'b0;
      else if (sck_fall)
        out_started_reg <= 1'b1;
      // Hold floats the pin but keeps the pending bit
      so_oe <= ~cs_s & hold_s & out_state & (out_started_reg | sck_fall);
    end
  end

  // ****************************************************************
  // Page buffer
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      buf_valid_reg <= '0;
    end
    else if (sck_rise && (state_reg == st_addr_wr) && (bit_cnt_reg == addr_last_bit))
      buf_valid_reg <= '0;
    else if (sck_rise && (state_reg == st_wr_data) && (bit_cnt_reg == byte_last_bit))
      buf_valid_reg[off_w'(ptr_reg & off_mask)] <= 1'b1;
  end

  // Later bytes at the same offset overwrite earlier ones
  always_ff @(posedge sys_clk)
  begin
    if (sck_rise && (state_reg == st_wr_data) && (bit_cnt_reg == byte_last_bit))
      page_buf[off_w'(ptr_reg & off_mask)] <= in_next[7:0];
  end

  // ****************************************************************
  // Program cycle and write latch
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      busy_reg <= 1'b0;
      wel_reg <= 1'b0;
      prog_cnt_reg <= 32'h0000_0000;
    end
    else if (busy_reg)
    begin
      prog_cnt_reg <= prog_cnt_reg + 32'h0000_0001;
      if (prog_done)
      begin
        busy_reg <= 1'b0;
        wel_reg <= 1'b0;
      end
    end
    else if (cs_rise)
    begin
      // Only a rise right after a whole data byte commits
      if ((state_reg == st_wr_data) && (bit_cnt_reg == cnt_zero) && (|buf_valid_reg))
      begin
        busy_reg <= 1'b1;
        prog_cnt_reg <= 32'h0000_0000;
      end
      else if (state_reg == st_set_wait)
        wel_reg <= 1'b1;
      else if (state_reg == st_clr_wait)
        wel_reg <= 1'b0;
    end
  end

  // Array storage has no reset, like the cells it models
  always_ff @(posedge sys_clk)
  begin
    if (prog_done)
    begin
      for (int i = 0; i < page_max; i++)
        if (buf_valid_reg[i])
          mem[page_base_reg | addr_w'(i)] <= page_buf[i];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      program_busy_flag <= 1'b0;
      write_latch_flag <= 1'b0;
    end
    else
    begin
      program_busy_flag <= busy_reg;
      write_latch_flag <= wel_reg;
    end
  end

endmodule // sep_core

// [sep_core_asserts.sv]
// ****
// Port checks
// ****
module sep_core_asserts
  import sep_pkg::*;
#(
  parameter int page_bytes = page_dflt,
  parameter int prog_cycles = prog_cycles_dflt
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic hold_n_pin,
  input wire logic protect_pin_enable,
  input wire logic block_protect_high,
  input wire logic block_protect_low,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic program_busy_flag,
  input wire logic write_latch_flag
);
  int cs_hi_cnt;
  int busy_cnt;
  // Saturates so a long idle spell cannot wrap
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !cs_n_pin)
      cs_hi_cnt <= 0;
    else if (cs_hi_cnt < 1000)
      cs_hi_cnt <= cs_hi_cnt + 1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !program_busy_flag)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Six cycles cover the pin synchroniser and output register
  sequence s_deselected;
    cs_n_pin [*6];
  endsequence
  sequence s_held;
    !hold_n_pin [*6];
  endsequence
  a_oe_off_deselect: assert property (s_deselected |-> !so_oe)
    else $error("output driven while deselected");
  a_oe_off_hold: assert property (s_held |-> !so_oe)
    else $error("output driven during hold");
  a_busy_at_rise: assert property ($rose(program_busy_flag) |-> cs_n_pin && cs_hi_cnt inside {[2:8]})
    else $error("busy started away from select rise");
  a_busy_length: assert property ($fell(program_busy_flag) |-> busy_cnt inside {[prog_cycles-2:prog_cycles+3]})
    else $error("program cycle length wrong");
  a_busy_holds: assert property ($rose(program_busy_flag) |=> program_busy_flag [*8])
    else $error("busy dropped early");
  a_latch_cleared: assert property ($fell(program_busy_flag) |-> ##[0:2] !write_latch_flag)
    else $error("latch kept after program");
  a_latch_on_desel: assert property ($rose(write_latch_flag) |-> cs_n_pin)
    else $error("latch set while selected");
  // Serial clock stays high four system cycles per bit in the bench
  a_so_steady_high: assert property (sck_pin [*4] |-> $stable(so_out))
    else $error("output moved while clock high");
endmodule // sep_core_asserts

bind sep_core sep_core_asserts #(.page_bytes(page_bytes), .prog_cycles(prog_cycles)) u_chk (
  .sys_clk, .sys_rst, .cs_n_pin, .sck_pin, .si_pin, .hold_n_pin, .protect_pin_enable,
  .block_protect_high, .block_protect_low, .so_out, .so_oe, .program_busy_flag,
  .write_latch_flag);

// [sep_host.sv]
// ****
// Bus master model, 800 ns serial clock
// ****
module sep_host (
  input wire logic sys_clk,
  input wire logic so_wire,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic sel;
    cs_n <= 1'b0;
    cyc(4);
  endtask
  task automatic desel;
    cyc(4);
    cs_n <= 1'b1;
    cyc(8);
  endtask
  // Sends the top nb bits; hold pauses before bit h, -1 for none
  task automatic xb(input logic [7:0] tx, input int h, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nb; i--)
    begin
      si <= tx[i];
      cyc(4);
      if (i == h)
      begin
        hold_n <= 1'b0;
        cyc(8);
        hold_n <= 1'b1;
        cyc(4);
      end
      sck <= 1'b1;
      cyc(4);
      rx[i] = so_wire;
      sck <= 1'b0;
    end
  endtask
endmodule // sep_host

// [tb_spi_eeprom_read_write_seq.sv]
module tb_spi_eeprom_read_write_seq;
  import sep_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int pc = 600;
  logic sys_clk, sys_rst, so_out, so_oe, busy, latch;
  logic cs_n, sck, si, hold_n, so_wire;
  logic protect_pin_enable_in, bp_hi_in, bp_lo_in;
  logic [7:0] s;
  int n_mismatch, cmp_count, cyc_cnt;
  // Released line shows the inverse of the last driven bit, never a held value
  assign so_wire = so_oe ? so_out : ~so_out;
  sep_core #(.page_bytes(16), .prog_cycles(pc)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si), .hold_n_pin(hold_n),
    .protect_pin_enable(protect_pin_enable_in), .block_protect_high(bp_hi_in), .block_protect_low(bp_lo_in),
    .so_out(so_out), .so_oe(so_oe), .program_busy_flag(busy), .write_latch_flag(latch));
  sep_host host (.sys_clk(sys_clk), .so_wire(so_wire), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    host.sel();
    host.xb(op, -1, 8, s);
    host.desel();
  endtask
  task automatic st;
    host.sel();
    host.xb(op_status_read, -1, 8, s);
    host.xb(8'h00, -1, 8, s);
    host.desel();
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] d[$], input int h);
    host.sel();
    host.xb(op_read, -1, 8, s);
    host.xb(a[15:8], -1, 8, s);
    host.xb(a[7:0], -1, 8, s);
    foreach (d[i])
    begin
      host.xb(8'h00, (i == 0) ? h : -1, 8, s);
      chk("read byte", d[i], s);
    end
    host.desel();
  endtask
  // Last byte sends only nb bits, to cut a write short
  task automatic wr(input logic [15:0] a, input logic [7:0] d[$], input int nb);
    host.sel();
    host.xb(op_write, -1, 8, s);
    host.xb(a[15:8], -1, 8, s);
    host.xb(a[7:0], -1, 8, s);
    foreach (d[i])
      host.xb(d[i], -1, (i == d.size() - 1) ? nb : 8, s);
    host.desel();
  endtask
  task automatic idle;
    for (int i = 0; i < pc + 100 && busy !== 1'b0; i++)
      @(posedge sys_clk);
    chk("busy end", 8'h00, {7'h0, busy});
    chk("latch end", 8'h00, {7'h0, latch});
  endtask
  task automatic t_latch;
    cmd(op_latch_set);
    chk("latch set", 8'h01, {7'h0, latch});
    st();
    chk("status", 8'h86, s);
    cmd(op_latch_clear);
    chk("latch clear", 8'h00, {7'h0, latch});
    host.sel();
    host.xb(op_latch_set, -1, 8, s);
    host.xb(8'h00, -1, 8, s);
    host.desel();
    chk("latch void", 8'h00, {7'h0, latch});
    wr(16'h0010, {8'h55}, 8);
    chk("write unlatched", 8'h00, {7'h0, busy});
    $display("t_latch done");
  endtask
  task automatic t_page;
    cmd(op_latch_set);
    wr(16'h0000, {8'h3c}, 8);
    idle();
    cmd(op_latch_set);
    wr(16'hf7fd, {8'ha1, 8'h5a, 8'hc3, 8'h96}, 8);
    chk("busy", 8'h01, {7'h0, busy});
    // Protect pins change under a running program; status must follow them
    protect_pin_enable_in <= 1'b0;
    bp_hi_in <= 1'b1;
    bp_lo_in <= 1'b0;
    st();
    chk("status busy", 8'h0b, s);
    host.sel();
    host.xb(op_read, -1, 8, s);
    host.xb(8'h07, -1, 8, s);
    host.xb(8'hfe, -1, 8, s);
    host.xb(8'h00, -1, 8, s);
    chk("oe in busy", 8'h00, {7'h0, so_oe});
    host.desel();
    idle();
    rd(16'hf7fe, {8'h5a, 8'hc3, 8'h3c}, 3);
    rd(16'h07f0, {8'h96}, -1);
    $display("t_page done");
  endtask
  task automatic t_cancel;
    cmd(op_latch_set);
    wr(16'h0020, {8'h99}, 4);
    chk("partial byte", 8'h00, {7'h0, busy});
    $display("t_cancel done");
  endtask
  initial
  begin
    n_mismatch = 0;
    cmp_count = 0;
    cyc_cnt = 0;
    protect_pin_enable_in = 1'b1;
    bp_hi_in = 1'b0;
    bp_lo_in = 1'b1;
    sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_latch();
    t_page();
    t_cancel();
    stop_test();
  end
endmodule // tb_spi_eeprom_read_write_seq
